// ==== tocc_pkg.sv ====
// constants for the timer output compare control block
// Notes on behaviour
// R1 - a forced compare does the pin action of a match but sets no flag
// R2 - a forced pin action happens at the next count transition after the write
// R3 - force bits for channels 1 to 5 in bits 7..3; zero writes do nothing
// R4 - software should not force a channel that toggles on compare
// R5 - channel-1 mask bits 7..3 let channel 1 drive port A pins 7..3
// R6 - on channel-1 match, masked data bits are copied to port A outputs
// R7 - the 16-bit counter is read-only and resets to zero
// R8 - reading the counter high byte latches the low byte for the next read
// R9 - channels 2..5 action pairs: 00 off, 01 toggle, 10 low, 11 high
// R10 - compare 5 works only while the capture-4 select bit is clear
// R11 - first enable register gates the first flags bit for bit into a request
// R12 - shared enable serves capture 4 when select is one, else compare 5
// R13 - first flags clear only on a one written; zero leaves them
// R14 - each compare flag sets whenever the counter equals its compare value
// R15 - shared flag is set by capture 4 or compare 5 as select picks
// R16 - capture flags 1..3 set on each selected edge event
// R17 - overflow enable at bit 7 requests while the overflow flag is set
// R18 - second enable bits pair bit for bit with the second flags; the code keeps enable bits 7..4 but has only the overflow flag at bit 7
// R19 - prescale select 00,01,10,11 divides the count clock by 1,4,8,16
// R20 - prescale select takes one write only, within 64 cycles of reset
// R21 - overflow flag sets when the counter rolls from all ones to zero
// R22 - writing a compare high byte suppresses that compare for one cycle
// R23 - forcing channel 1 applies its masked data like a real match
package tocc_pkg;
   localparam logic [13:0] IDX_FORCE = 14'h100B;
   localparam logic [13:0] IDX_MASK = 14'h100C;
   localparam logic [13:0] IDX_DATA = 14'h100D;
   localparam logic [13:0] IDX_CNT_HI = 14'h100E;
   localparam logic [13:0] IDX_CNT_LO = 14'h100F;
   localparam logic [13:0] IDX_TOC_FIRST = 14'h1016;
   localparam logic [13:0] IDX_TOC_LAST = 14'h101F;
   localparam logic [13:0] IDX_ACTION = 14'h1020;
   localparam logic [13:0] IDX_IEN1 = 14'h1022;
   localparam logic [13:0] IDX_FLG1 = 14'h1023;
   localparam logic [13:0] IDX_IEN2 = 14'h1024;
   localparam logic [13:0] IDX_FLG2 = 14'h1025;
   localparam logic [13:0] IDX_SEL = 14'h1030;
   localparam logic [15:0] RST_TOC = 16'hFFFF;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] PIN_BITS = 8'hF8;
   localparam logic [7:0] IEN2_BITS = 8'hF0;
   localparam logic [6:0] PRESC_WIN_CYC = 7'h40;
   localparam int NCH = 5;
   localparam int TOF_BIT = 7;
   localparam int SEL_BIT = 0;
endpackage

// ==== tocc_timer_ctrl.sv ====
// output compare control: force, channel-1 mask/data, counter, flags, prescaler
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tocc_timer_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] capture_evt_i,
   output logic [15:0] count_o,
   output logic [4:0] port_a_upper_pins_o,
   output logic [4:0] port_a_upper_pins_oe_o,
   output logic cc_irq_o,
   output logic ovf_irq_o
);

   localparam int NCH_L = tocc_pkg::NCH;

   function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
      return (a[1:0] == 2'b00) && (a[15:2] == idx);
   endfunction

   // bus state
   logic ack_r;
   logic [7:0] rdat_r;
   logic [7:0] rdat_nxt;
   logic [7:0] buf_r;
   logic [7:0] buf_nxt;
   logic buf_vld_r;
   logic buf_vld_nxt;
   // software registers
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   logic [7:0] action_r;
   logic [7:0] action_nxt;
   logic [7:0] ien1_r;
   logic [7:0] ien1_nxt;
   logic [7:0] flg1_r;
   logic [7:0] flg1_nxt;
   logic [7:0] ien2_r;
   logic [7:0] ien2_nxt;
   logic [1:0] pr_r;
   logic [1:0] pr_nxt;
   logic pr_done_r;
   logic pr_done_nxt;
   logic [6:0] win_r;
   logic [6:0] win_nxt;
   logic tof_r;
   logic tof_nxt;
   logic sel_r;
   logic sel_nxt;
   // counter and compare state
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [3:0] pre_r;
   logic [3:0] pre_nxt;
   logic [3:0] pre_term;
   logic tick;
   logic tick_d_r;
   logic [15:0] toc_r [NCH_L];
   logic [15:0] toc_nxt [NCH_L];
   logic [4:0] inh_r;
   logic [4:0] inh_nxt;
   logic [4:0] pend_r;
   logic [4:0] pend_nxt;
   logic [4:0] match;
   logic [4:0] act;
   logic [4:0] pin_r;
   logic [4:0] pin_nxt;
   logic [4:0] oe;
   logic [7:0] set1;

   // bus decode
   logic req;
   logic first;
   logic wr_go;
   logic rd_first;
   logic [7:0] wd;
   logic [13:0] toff;
   logic in_toc;
   logic [2:0] tch;
   logic thi;

   assign req = wb_cyc_i & wb_stb_i;
   assign first = req & ~ack_r;
   // writes land on the edge where the master sees ack
   assign wr_go = req & ack_r & wb_we_i & wb_sel_i[0];
   assign rd_first = first & ~wb_we_i;
   assign wd = wb_dat_i[7:0];
   assign toff = wb_adr_i[15:2] - tocc_pkg::IDX_TOC_FIRST;
   assign in_toc = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i[15:2] >= tocc_pkg::IDX_TOC_FIRST)
                   && (wb_adr_i[15:2] <= tocc_pkg::IDX_TOC_LAST);
   assign tch = toff[3:1];
   assign thi = ~toff[0];

   // read mux, sampled in the first cycle of a request
   always_comb begin
      rdat_nxt = rdat_r;
      buf_nxt = buf_r;
      buf_vld_nxt = buf_vld_r;
      if (first) begin
         buf_vld_nxt = 1'b0;
         rdat_nxt = 8'h00;
      end
      if (rd_first) begin
         if (hit(wb_adr_i, tocc_pkg::IDX_MASK)) begin
            rdat_nxt = mask_r;
         end else if (hit(wb_adr_i, tocc_pkg::IDX_DATA)) begin
            rdat_nxt = data_r;
         end else if (hit(wb_adr_i, tocc_pkg::IDX_CNT_HI)) begin
            rdat_nxt = cnt_r[15:8];
            buf_nxt = cnt_r[7:0]; // R8
            buf_vld_nxt = 1'b1; // R8
         end else if (hit(wb_adr_i, tocc_pkg::IDX_CNT_LO)) begin
            rdat_nxt = buf_vld_r ? buf_r : cnt_r[7:0]; // R8
         end else if (in_toc) begin
            rdat_nxt = thi ? toc_r[tch][15:8] : toc_r[tch][7:0];
         end else if (hit(wb_adr_i, tocc_pkg::IDX_ACTION)) begin
            rdat_nxt = action_r;
         end else if (hit(wb_adr_i, tocc_pkg::IDX_IEN1)) begin
            rdat_nxt = ien1_r;
         end else if (hit(wb_adr_i, tocc_pkg::IDX_FLG1)) begin
            rdat_nxt = flg1_r;
         end else if (hit(wb_adr_i, tocc_pkg::IDX_IEN2)) begin
            rdat_nxt = {ien2_r[7:4], 2'b00, pr_r};
         end else if (hit(wb_adr_i, tocc_pkg::IDX_FLG2)) begin
            rdat_nxt = {tof_r, 7'h00};
         end else if (hit(wb_adr_i, tocc_pkg::IDX_SEL)) begin
            rdat_nxt = {7'h00, sel_r};
         end
         // force register and unmapped words read zero
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= tocc_pkg::RST_REG;
         buf_r <= tocc_pkg::RST_REG;
         buf_vld_r <= 1'b0;
      end else begin
         ack_r <= first;
         rdat_r <= rdat_nxt;
         buf_r <= buf_nxt;
         buf_vld_r <= buf_vld_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = {24'h00_0000, rdat_r};

   // prescaler and free-running counter
   always_comb begin
      unique case (pr_r) // R19
         2'b00: pre_term = 4'h0;
         2'b01: pre_term = 4'h3;
         2'b10: pre_term = 4'h7;
         2'b11: pre_term = 4'hF;
      endcase
   end

   // a change of ratio cannot overshoot: >= ticks at once; only possible early on
   assign tick = (pre_r >= pre_term);

   always_comb begin
      pre_nxt = tick ? 4'h0 : pre_r + 4'h1;
      cnt_nxt = tick ? cnt_r + 16'h0001 : cnt_r; // R7
      pend_nxt = tick ? 5'b00000 : pend_r;
      for (int i = 0; i < NCH_L; i++) begin
         toc_nxt[i] = toc_r[i];
         inh_nxt[i] = 1'b0;
         if (wr_go && hit(wb_adr_i, tocc_pkg::IDX_FORCE) && wd[7 - i]) begin
            pend_nxt[i] = 1'b1; // R3
         end
         if (wr_go && in_toc && (tch == 3'(i))) begin
            if (thi) begin
               toc_nxt[i][15:8] = wd;
               inh_nxt[i] = 1'b1; // R22
            end else begin
               toc_nxt[i][7:0] = wd;
            end
         end
         // compare once per new count value, so a slow prescale still hits once
         match[i] = tick_d_r && !inh_r[i] && (cnt_r == toc_r[i]); // R14
         act[i] = match[i] | (tick & pend_r[i]); // R1 R2
      end
      match[4] = match[4] & ~sel_r; // R10
      act[4] = act[4] & ~sel_r; // R10
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_r <= 4'h0;
         cnt_r <= tocc_pkg::RST_CNT; // R7
         tick_d_r <= 1'b0;
         pend_r <= 5'b00000;
         inh_r <= 5'b00000;
         for (int i = 0; i < NCH_L; i++) begin
            toc_r[i] <= tocc_pkg::RST_TOC;
         end
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         tick_d_r <= tick;
         pend_r <= pend_nxt;
         inh_r <= inh_nxt;
         for (int i = 0; i < NCH_L; i++) begin
            toc_r[i] <= toc_nxt[i];
         end
      end
   end

   assign count_o = cnt_r;

   // pin actions; channel 1 is applied last so its masked data wins
   always_comb begin
      pin_nxt = pin_r;
      oe = mask_r[7:3]; // R5
      for (int i = 1; i < NCH_L; i++) begin
         if ({action_r[9 - 2 * i], action_r[8 - 2 * i]} != 2'b00 && !(i == 4 && sel_r)) begin
            oe[4 - i] = 1'b1;
         end
         if (act[i]) begin
            unique case ({action_r[9 - 2 * i], action_r[8 - 2 * i]}) // R9
               2'b00: pin_nxt[4 - i] = pin_nxt[4 - i];
               2'b01: pin_nxt[4 - i] = ~pin_r[4 - i];
               2'b10: pin_nxt[4 - i] = 1'b0;
               2'b11: pin_nxt[4 - i] = 1'b1;
            endcase
         end
      end
      if (act[0]) begin
         pin_nxt = (pin_nxt & ~mask_r[7:3]) | (data_r[7:3] & mask_r[7:3]); // R6 R23
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_r <= 5'b00000;
      end else begin
         pin_r <= pin_nxt;
      end
   end

   assign port_a_upper_pins_o = pin_r;
   assign port_a_upper_pins_oe_o = oe;

   // register file, flags and write-once prescale
   assign set1 = {match[0], match[1], match[2], match[3],
                  sel_r ? capture_evt_i[3] : match[4], // R15
                  capture_evt_i[0], capture_evt_i[1], capture_evt_i[2]}; // R16

   always_comb begin
      mask_nxt = mask_r;
      data_nxt = data_r;
      action_nxt = action_r;
      ien1_nxt = ien1_r;
      ien2_nxt = ien2_r;
      pr_nxt = pr_r;
      pr_done_nxt = pr_done_r;
      sel_nxt = sel_r;
      win_nxt = (win_r == tocc_pkg::PRESC_WIN_CYC) ? win_r : win_r + 7'h01;
      flg1_nxt = flg1_r;
      tof_nxt = tof_r;
      if (wr_go) begin
         if (hit(wb_adr_i, tocc_pkg::IDX_MASK)) begin
            mask_nxt = wd & tocc_pkg::PIN_BITS; // R5
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_DATA)) begin
            data_nxt = wd & tocc_pkg::PIN_BITS; // R6
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_ACTION)) begin
            action_nxt = wd;
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_IEN1)) begin
            ien1_nxt = wd;
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_IEN2)) begin
            ien2_nxt = wd & tocc_pkg::IEN2_BITS; // R18
            if (!pr_done_r && win_r < tocc_pkg::PRESC_WIN_CYC) begin
               pr_nxt = wd[1:0]; // R20
               pr_done_nxt = 1'b1; // R20
            end
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_FLG1)) begin
            flg1_nxt = flg1_r & ~wd; // R13
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_FLG2) && wd[tocc_pkg::TOF_BIT]) begin
            tof_nxt = 1'b0;
         end
         if (hit(wb_adr_i, tocc_pkg::IDX_SEL)) begin
            sel_nxt = wd[tocc_pkg::SEL_BIT];
         end
      end
      // a set in the clearing cycle is kept
      flg1_nxt = flg1_nxt | set1; // R14
      if (tick && cnt_r == 16'hFFFF) begin
         tof_nxt = 1'b1; // R21
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_r <= tocc_pkg::RST_REG;
         data_r <= tocc_pkg::RST_REG;
         action_r <= tocc_pkg::RST_REG;
         ien1_r <= tocc_pkg::RST_REG;
         ien2_r <= tocc_pkg::RST_REG;
         flg1_r <= tocc_pkg::RST_REG;
         pr_r <= 2'b00;
         pr_done_r <= 1'b0;
         win_r <= 7'h00;
         tof_r <= 1'b0;
         sel_r <= 1'b0;
      end else begin
         mask_r <= mask_nxt;
         data_r <= data_nxt;
         action_r <= action_nxt;
         ien1_r <= ien1_nxt;
         ien2_r <= ien2_nxt;
         flg1_r <= flg1_nxt;
         pr_r <= pr_nxt;
         pr_done_r <= pr_done_nxt;
         win_r <= win_nxt;
         tof_r <= tof_nxt;
         sel_r <= sel_nxt;
      end
   end

   // shared enable bit 3 pairs with the shared flag, whichever source owns it
   assign cc_irq_o = |(ien1_r & flg1_r); // R11 R12
   assign ovf_irq_o = ien2_r[tocc_pkg::TOF_BIT] & tof_r; // R17

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_force1_wr;
      wr_go && hit(wb_adr_i, tocc_pkg::IDX_FORCE) && wd[7];
   endsequence
   sequence s_cnt_hi_rd;
      rd_first && hit(wb_adr_i, tocc_pkg::IDX_CNT_HI);
   endsequence

   property p_force_no_flag;
      $rose(flg1_r[7]) |-> $past(match[0]);
   endproperty
   a_force_no_flag: assert property (p_force_no_flag) else $error("compare 1 flag rose without a match"); // R1

   property p_force_timely;
      s_force1_wr |-> ##[1:17] (tick && act[0]);
   endproperty
   a_force_timely: assert property (p_force_timely) else $error("forced action missed next tick"); // R2

   property p_force_reads_zero;
      rd_first && hit(wb_adr_i, tocc_pkg::IDX_FORCE) |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
   endproperty
   a_force_reads_zero: assert property (p_force_reads_zero) else $error("force register read not zero"); // R3

   property p_ch1_data;
      act[0] |=> (port_a_upper_pins_o & $past(mask_r[7:3])) == ($past(data_r[7:3]) & $past(mask_r[7:3]));
   endproperty
   a_ch1_data: assert property (p_ch1_data) else $error("channel 1 data not on masked pins"); // R6

   property p_cnt_step;
      $changed(cnt_r) |-> cnt_r == $past(cnt_r) + 16'h0001;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter moved by other than one"); // R7

   property p_cnt_latch;
      s_cnt_hi_rd |=> buf_vld_r && buf_r == $past(cnt_r[7:0]);
   endproperty
   a_cnt_latch: assert property (p_cnt_latch) else $error("low byte not latched on high read"); // R8

   property p_set_high;
      act[1] && action_r[7:6] == 2'b11 && !act[0] |=> port_a_upper_pins_o[3];
   endproperty
   a_set_high: assert property (p_set_high) else $error("channel 2 set-high not applied"); // R9

   property p_w1c;
      wr_go && hit(wb_adr_i, tocc_pkg::IDX_FLG1) && wd[2] && !capture_evt_i[0] |=> !flg1_r[2];
   endproperty
   a_w1c: assert property (p_w1c) else $error("capture 1 flag not cleared"); // R13

   property p_pr_once;
      wr_go && hit(wb_adr_i, tocc_pkg::IDX_IEN2) && (pr_done_r || win_r >= tocc_pkg::PRESC_WIN_CYC) |=> $stable(pr_r);
   endproperty
   a_pr_once: assert property (p_pr_once) else $error("prescale changed outside its window"); // R20

   property p_overflow;
      tick && cnt_r == 16'hFFFF |=> tof_r && cnt_r == 16'h0000;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag not set on rollover"); // R21

   property p_inhibit;
      wr_go && in_toc && thi |=> !match[$past(tch)];
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("compare not suppressed after high write"); // R22

endmodule
`default_nettype wire

// ==== tocc_tb.sv ====
// self-checking bench for the timer output compare control block
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_i;
   logic rst_i;
   logic wb_cyc_i;
   logic wb_stb_i;
   logic wb_we_i;
   logic [15:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] capture_evt_i;
   logic [15:0] count_o;
   logic [4:0] pins;
   logic [4:0] pins_oe;
   logic cc_irq_o;
   logic ovf_irq_o;
   int err_count;
   int compares;
   int n;
   logic [7:0] rd;
   logic [7:0] hi;
   logic [15:0] c0;
   logic [15:0] tgt;
   logic [13:0] rb_idx[4];
   logic [7:0] rb_exp[4] = '{8'hF8, 8'hF8, 8'hFF, 8'hFF};
   logic [7:0] act3[4] = '{8'h30, 8'h20, 8'h30, 8'h00};
   logic [4:0] pin3[4] = '{5'h04, 5'h00, 5'h04, 5'h04};
   logic [4:0] oe3[4] = '{5'h04, 5'h04, 5'h04, 5'h00};

   tocc_timer_ctrl dut_u (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .capture_evt_i(capture_evt_i),
      .count_o(count_o),
      .port_a_upper_pins_o(pins),
      .port_a_upper_pins_oe_o(pins_oe),
      .cc_irq_o(cc_irq_o),
      .ovf_irq_o(ovf_irq_o)
   );

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one classic cycle; request held until ack is sampled high
   task automatic xfer(input logic [13:0] idx, input logic we, input logic [7:0] d, output logic [7:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED bus ack expected 1 seen %b", wb_ack_o);
         print_verdict();
      end
   endtask

   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      logic [7:0] q;
      xfer(idx, 1'b1, d, q);
   endtask

   task automatic rchk(input string what, input logic [13:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      xfer(idx, 1'b0, 8'h00, q);
      chk(what, {8'h00, exp}, {8'h00, q});
   endtask

   // bounded wait; a pin that never arrives shows up as a mismatch
   task automatic wait_pins(input logic [4:0] exp, input int bound);
      int k;
      k = 0;
      while (pins !== exp && k < bound) begin
         @(posedge clk_i);
         k++;
      end
      chk("pins", {11'h000, exp}, {11'h000, pins});
   endtask

   task automatic pulse(input logic [3:0] e);
      @(posedge clk_i);
      capture_evt_i <= e;
      @(posedge clk_i);
      capture_evt_i <= 4'h0;
   endtask

   initial begin
      err_count = 0;
      compares = 0;
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 16'h0000;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0000_0000;
      capture_evt_i = 4'h0;
      rb_idx = '{tocc_pkg::IDX_MASK, tocc_pkg::IDX_DATA, tocc_pkg::IDX_ACTION, tocc_pkg::IDX_IEN1};
      repeat (4) @(posedge clk_i);
      chk("count in reset", 16'h0000, count_o);
      chk("irqs in reset", 16'h0000, {14'h0000, cc_irq_o, ovf_irq_o});
      rst_i <= 1'b0;
      // prescale must be set inside the window right after reset
      wr(tocc_pkg::IDX_IEN2, 8'h80);
      rchk("enable2", tocc_pkg::IDX_IEN2, 8'h80);
      wr(tocc_pkg::IDX_IEN2, 8'h83);
      rchk("enable2 locked", tocc_pkg::IDX_IEN2, 8'h80);
      c0 = count_o;
      repeat (16) @(posedge clk_i);
      chk("count rate", c0 + 16'h0010, count_o);
      $display("test prescale done");
      rchk("force reads", tocc_pkg::IDX_FORCE, 8'h00);
      rchk("flags1 reset", tocc_pkg::IDX_FLG1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rchk("reset value", rb_idx[i], 8'h00);
         wr(rb_idx[i], 8'hFF);
         rchk("readback", rb_idx[i], rb_exp[i]);
         wr(rb_idx[i], 8'h00);
      end
      rchk("unmapped", 14'h1021, 8'h00);
      $display("test registers done");
      c0 = count_o;
      xfer(tocc_pkg::IDX_CNT_HI, 1'b0, 8'h00, hi);
      xfer(tocc_pkg::IDX_CNT_LO, 1'b0, 8'h00, rd);
      chk("count pair", 16'h0001, {15'h0000, ({hi, rd} >= c0 && {hi, rd} <= c0 + 16'h0002)});
      $display("test counter read done");
      for (int i = 0; i < 3; i++) begin
         pulse(4'h1 << i);
         rchk("capture flag", tocc_pkg::IDX_FLG1, 8'h04 >> i);
         wr(tocc_pkg::IDX_IEN1, 8'h04 >> i);
         @(posedge clk_i);
         chk("cc irq on", 16'h0001, {15'h0000, cc_irq_o});
         wr(tocc_pkg::IDX_FLG1, 8'h00);
         rchk("flag kept", tocc_pkg::IDX_FLG1, 8'h04 >> i);
         wr(tocc_pkg::IDX_FLG1, 8'h04 >> i);
         rchk("flag cleared", tocc_pkg::IDX_FLG1, 8'h00);
         chk("cc irq off", 16'h0000, {15'h0000, cc_irq_o});
         wr(tocc_pkg::IDX_IEN1, 8'h00);
      end
      pulse(4'h8);
      rchk("capture4 unselected", tocc_pkg::IDX_FLG1, 8'h00);
      wr(tocc_pkg::IDX_SEL, 8'h01);
      pulse(4'h8);
      rchk("capture4 selected", tocc_pkg::IDX_FLG1, 8'h08);
      wr(tocc_pkg::IDX_IEN1, 8'h08);
      @(posedge clk_i);
      chk("shared irq", 16'h0001, {15'h0000, cc_irq_o});
      wr(tocc_pkg::IDX_FLG1, 8'h08);
      wr(tocc_pkg::IDX_IEN1, 8'h00);
      wr(tocc_pkg::IDX_SEL, 8'h00);
      $display("test captures done");
      wr(tocc_pkg::IDX_ACTION, 8'hC0);
      tgt = count_o + 16'h012C;
      wr(tocc_pkg::IDX_TOC_FIRST + 14'h0002, tgt[15:8]);
      wr(tocc_pkg::IDX_TOC_FIRST + 14'h0003, tgt[7:0]);
      wait_pins(5'h08, 600);
      chk("oe ch2", 16'h0008, {11'h000, pins_oe});
      rchk("compare flag", tocc_pkg::IDX_FLG1, 8'h40);
      wr(tocc_pkg::IDX_FLG1, 8'hFF);
      // forced low must land on the next tick and leave the flag alone
      wr(tocc_pkg::IDX_ACTION, 8'h80);
      wr(tocc_pkg::IDX_FORCE, 8'h40);
      wait_pins(5'h00, 4);
      rchk("no flag on force", tocc_pkg::IDX_FLG1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(tocc_pkg::IDX_ACTION, act3[i]);
         wr(tocc_pkg::IDX_FORCE, 8'h20);
         if (i < 3) wait_pins(pin3[i], 4);
         @(posedge clk_i);
         chk("oe ch3", {11'h000, oe3[i]}, {11'h000, pins_oe});
      end
      // toggle only by a real match; a force next to a match could misbehave
      wr(tocc_pkg::IDX_ACTION, 8'h10);
      tgt = count_o + 16'h0040;
      wr(tocc_pkg::IDX_TOC_FIRST + 14'h0004, tgt[15:8]);
      wr(tocc_pkg::IDX_TOC_FIRST + 14'h0005, tgt[7:0]);
      wait_pins(5'h00, 200);
      rchk("toggle flag", tocc_pkg::IDX_FLG1, 8'h20);
      wr(tocc_pkg::IDX_FLG1, 8'h20);
      $display("test pin actions done");
      wr(tocc_pkg::IDX_ACTION, 8'h00);
      wr(tocc_pkg::IDX_MASK, 8'hF8);
      wr(tocc_pkg::IDX_DATA, 8'h50);
      wr(tocc_pkg::IDX_FORCE, 8'h80);
      wait_pins(5'h0A, 4);
      chk("oe ch1", 16'h001F, {11'h000, pins_oe});
      wr(tocc_pkg::IDX_MASK, 8'h08);
      wr(tocc_pkg::IDX_DATA, 8'hF8);
      wr(tocc_pkg::IDX_FORCE, 8'h80);
      wait_pins(5'h0B, 4);
      rchk("no flag on force1", tocc_pkg::IDX_FLG1, 8'h00);
      $display("test channel1 done");
      n = 0;
      while (count_o !== 16'hFFFF && n < 70000) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      while (ovf_irq_o !== 1'b1 && n < 4) begin
         @(posedge clk_i);
         n++;
      end
      chk("ovf irq", 16'h0001, {15'h0000, ovf_irq_o});
      rchk("flags2", tocc_pkg::IDX_FLG2, 8'h80);
      rchk("flags1 at all ones", tocc_pkg::IDX_FLG1, 8'h98);
      wr(tocc_pkg::IDX_IEN2, 8'h00);
      @(posedge clk_i);
      chk("ovf irq masked", 16'h0000, {15'h0000, ovf_irq_o});
      wr(tocc_pkg::IDX_FLG2, 8'h80);
      rchk("flags2 cleared", tocc_pkg::IDX_FLG2, 8'h00);
      wr(tocc_pkg::IDX_IEN2, 8'h80);
      @(posedge clk_i);
      chk("ovf irq idle", 16'h0000, {15'h0000, ovf_irq_o});
      $display("test overflow done");
      // a mid-run reset reopens the one-shot prescale window
      for (int p = 1; p < 4; p++) begin
         @(posedge clk_i);
         rst_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         chk("count after reset", 16'h0000, count_o);
         rst_i <= 1'b0;
         wr(tocc_pkg::IDX_IEN2, 8'(p));
         c0 = count_o;
         repeat (64) @(posedge clk_i);
         chk("count divided", 16'h0040 >> (p + 1), count_o - c0);
      end
      $display("test prescale ratios done");
      print_verdict();
   end
endmodule
`default_nettype wire
